//--- hdl/ubf_pkg.sv
// Package with the constants, types and register map of the bulk frame transport.
package ubf_pkg;
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_DELAY = 8'h04;
	localparam logic [7:0] REG_CAP = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam int CFG_MULTI = 0;
	localparam int CFG_EMPTY_SEL = 1;
	localparam int CFG_LIMIT_EN = 2;
	localparam int CFG_STALL_DIS = 3;
	localparam int CFG_BURST_LO = 4;
	localparam logic [31:0] CFG_RESET = 32'h0000_0001;
	localparam int DELAY_US = 34;
	localparam logic [31:0] DELAY_RESET = 32'h0000_0022;
	localparam logic [31:0] CAP_RESET = 32'h0000_0000;
	localparam int CLK_NS = 8;
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = US_NS / CLK_NS;
	localparam logic [10:0] MPS_SS = 11'h400;
	localparam logic [10:0] MPS_HS = 11'h200;
	localparam logic [10:0] MPS_FS = 11'h040;
	localparam int TX_BYTES = 8192;
	localparam int OUT_WORDS = 2048;
	localparam int CMD_DEPTH = 32;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SPD_FS = 2'b00,
		SPD_HS = 2'b01,
		SPD_SS = 2'b10
	} ubf_speed_e;
	typedef struct packed {
		logic send;
		logic nak;
		logic nrdy;
		logic [10:0] len;
	} ubf_in_rsp_s;
	typedef struct packed {
		logic term;
		logic [10:0] len;
	} ubf_cmd_s;
endpackage

//--- hdl/ubf_transport.sv
// Bulk In packet former and Bulk Out buffer between the frame FIFO and the USB device controller.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
module ubf_transport (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire ubf_pkg::ubf_speed_e SPEED,
	input wire logic RXF_AVAIL,
	input wire logic [13:0] RXF_LEN,
	input wire logic RXF_MORE,
	output logic RXF_TAKE,
	input wire logic IN_TOKEN,
	output ubf_pkg::ubf_in_rsp_s IN_RSP,
	input wire logic IN_ACK,
	input wire logic IN_NOACK,
	output logic REWIND,
	output logic ADVANCE,
	input wire logic OUT_WR,
	input wire logic [31:0] OUT_DATA,
	output logic OUT_READY,
	input wire logic OUT_DONE,
	input wire logic OUT_OK,
	input wire logic LOS,
	output logic OUT_STALL,
	output logic TXF_AVAIL,
	input wire logic TXF_RD,
	output logic [31:0] TXF_DATA
);
	import ubf_pkg::*;

	function automatic logic [10:0] mps_of(input ubf_speed_e s);
		case (s)
			SPD_SS: mps_of = MPS_SS;
			SPD_HS: mps_of = MPS_HS;
			default: mps_of = MPS_FS;
		endcase
	endfunction

	function automatic logic [13:0] rnd4(input logic [13:0] n);
		rnd4 = (n + 14'h0003) & 14'h3FFC;
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		end
		wmerge = o;
	endfunction

	logic [31:0] cfg;
	logic [31:0] dly;
	logic [31:0] cap;
	logic aw_ok;
	logic w_ok;
	logic [7:0] aw_addr;
	logic [31:0] wdat;
	logic [3:0] wstrb;
	logic stall_clr;
	logic multi;
	logic lim_en;
	logic [10:0] mps;
	logic [4:0] burst_sz;
	ubf_cmd_s cmdq [CMD_DEPTH];
	logic [5:0] wr_p;
	logic [5:0] rd_p;
	logic [5:0] snd_p;
	logic [5:0] unsent;
	logic [5:0] depth;
	logic [5:0] term_cnt;
	logic [13:0] cur_len;
	logic [25:0] burst_cur;
	logic [25:0] burst_max;
	logic [13:0] used;
	logic closing;
	logic [6:0] us_cnt;
	logic us_tick;
	logic [15:0] tmr;
	logic delay_done;
	logic do_split;
	logic do_close;
	logic do_take;
	logic cap_hit;
	logic empty_all;
	logic may_send;
	logic outst;
	logic [13:0] add_len;
	logic [13:0] ack_bytes;
	logic out_stall_q;
	logic [31:0] obuf [OUT_WORDS];
	logic [11:0] owp;
	logic [11:0] cwp;
	logic [11:0] frp;

	assign multi = cfg[CFG_MULTI];
	assign lim_en = cfg[CFG_LIMIT_EN];
	assign mps = mps_of(SPEED);
	assign burst_sz = {1'b0, cfg[CFG_BURST_LO +: 4]} + 5'h01;
	assign burst_max = 26'(cap[15:0]) * 26'(mps);
	assign depth = wr_p - rd_p;
	assign unsent = wr_p - snd_p;
	assign outst = snd_p != rd_p;

	// Register slave: address and data are caught independently, write happens once both are in.
	assign S_AXI_AWREADY = !aw_ok;
	assign S_AXI_WREADY = !w_ok;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			aw_addr <= 8'h00;
			wdat <= 32'h0000_0000;
			wstrb <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OK;
			cfg <= CFG_RESET;
			dly <= DELAY_RESET;
			cap <= CAP_RESET;
			stall_clr <= 1'b0;
		end else begin
			stall_clr <= 1'b0;
			if (S_AXI_AWVALID && !aw_ok) begin
				aw_ok <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_ok) begin
				w_ok <= 1'b1;
				wdat <= S_AXI_WDATA;
				wstrb <= S_AXI_WSTRB;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
			if (aw_ok && w_ok && !S_AXI_BVALID) begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= RESP_OK;
				case ({aw_addr[7:2], 2'b00})
					REG_CFG: cfg <= wmerge(cfg, wdat, wstrb);
					REG_DELAY: dly <= wmerge(dly, wdat, wstrb);
					REG_CAP: cap <= wmerge(cap, wdat, wstrb);
					REG_STATUS: stall_clr <= wstrb[0] & wdat[0];
					default: S_AXI_BRESP <= RESP_SLVERR;
				endcase
			end
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OK;
		end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= RESP_OK;
			case ({S_AXI_ARADDR[7:2], 2'b00})
				REG_CFG: S_AXI_RDATA <= cfg;
				REG_DELAY: S_AXI_RDATA <= dly;
				REG_CAP: S_AXI_RDATA <= cap;
				REG_STATUS: S_AXI_RDATA <= {10'h000, used, closing, depth, out_stall_q};
				default: begin
					S_AXI_RDATA <= 32'h0000_0000;
					S_AXI_RRESP <= RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// The tick restarts with the timer, so a delay is never cut short by a partial microsecond.
	assign us_tick = us_cnt == 7'(CYC_PER_US - 1);
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			us_cnt <= 7'h00;
		end else begin
			us_cnt <= (us_tick || do_take || do_split || (IN_RSP.send && IN_RSP.len == mps)) ?
				7'h00 : us_cnt + 7'h01;
		end
	end

	assign delay_done = (dly[15:0] == 16'h0000) || (tmr >= dly[15:0]);

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tmr <= 16'h0000;
		end else if (do_take || do_split || (IN_RSP.send && IN_RSP.len == mps)) begin
			tmr <= 16'h0000;
		end else if (us_tick && !delay_done) begin
			tmr <= tmr + 16'h0001;
		end
	end

	// Packet former. A frame enters a burst whole, so a burst never ends inside a frame.
	assign add_len = (multi && RXF_MORE) ? rnd4(RXF_LEN) : RXF_LEN;
	assign cap_hit = lim_en && burst_cur != 26'h0 &&
		burst_cur + 26'(RXF_LEN) > burst_max;
	assign do_split = depth != 6'(CMD_DEPTH) && cur_len >= 14'(mps);
	assign do_close = depth != 6'(CMD_DEPTH) && !do_split && (closing ||
		(multi && burst_cur != 26'h0 && (cap_hit || (!RXF_AVAIL && delay_done))));
	assign do_take = RXF_AVAIL && !closing && !do_split && !do_close && !cap_hit &&
		cur_len < 14'(mps) &&
		{1'b0, used} + {1'b0, cur_len} + {1'b0, add_len} <= 15'(TX_BYTES);
	assign RXF_TAKE = do_take;
	assign ack_bytes = rnd4({3'b000, cmdq[rd_p[4:0]].len});

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wr_p <= 6'h00;
			cur_len <= 14'h0000;
			burst_cur <= 26'h0;
			closing <= 1'b0;
		end else if (do_split) begin
			cmdq[wr_p[4:0]] <= '{term: 1'b0, len: mps};
			wr_p <= wr_p + 6'h01;
			cur_len <= cur_len - 14'(mps);
		end else if (do_close) begin
			// A zero remainder becomes a ZLP, closing a frame of exact packet multiples.
			cmdq[wr_p[4:0]] <= '{term: 1'b1, len: cur_len[10:0]};
			wr_p <= wr_p + 6'h01;
			cur_len <= 14'h0000;
			burst_cur <= 26'h0;
			closing <= 1'b0;
		end else if (do_take) begin
			cur_len <= cur_len + add_len;
			burst_cur <= burst_cur + 26'(RXF_LEN);
			closing <= !multi;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			used <= 14'h0000;
			term_cnt <= 6'h00;
		end else begin
			used <= used + ((do_split || do_close) ? rnd4(do_split ? 14'(mps) : cur_len) : 14'h0)
				- ((IN_ACK && outst) ? ack_bytes : 14'h0);
			term_cnt <= term_cnt + 6'(do_close) - 6'(IN_ACK && outst && cmdq[rd_p[4:0]].term);
		end
	end

	// Token answer. Full packets go at once on HS/FS; SS waits for a burst or a terminator.
	assign empty_all = depth == 6'h00 && !RXF_AVAIL && cur_len == 14'h0 && burst_cur == 26'h0;
	assign may_send = (SPEED == SPD_SS) ?
		(unsent >= 6'(burst_sz) || (unsent != 6'h00 && term_cnt != 6'h00)) :
		unsent != 6'h00;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			IN_RSP <= '0;
			snd_p <= 6'h00;
			rd_p <= 6'h00;
			REWIND <= 1'b0;
			ADVANCE <= 1'b0;
		end else begin
			IN_RSP <= '0;
			REWIND <= 1'b0;
			ADVANCE <= 1'b0;
			if (IN_NOACK && outst) begin
				snd_p <= rd_p;
				REWIND <= 1'b1;
			end else if (IN_TOKEN && may_send) begin
				IN_RSP.send <= 1'b1;
				IN_RSP.len <= cmdq[snd_p[4:0]].len;
				snd_p <= snd_p + 6'h01;
			end else if (IN_TOKEN && empty_all && !lim_en && !cfg[CFG_EMPTY_SEL]) begin
				IN_RSP.send <= 1'b1;
			end else if (IN_TOKEN) begin
				IN_RSP.nak <= SPEED != SPD_SS;
				IN_RSP.nrdy <= SPEED == SPD_SS;
			end
			if (IN_ACK && outst) begin
				rd_p <= rd_p + 6'h01;
				ADVANCE <= 1'b1;
			end
		end
	end

	// Bulk Out buffer: words land at a tentative pointer until the packet is judged.
	assign OUT_READY = (owp - frp) != 12'(OUT_WORDS - 1);
	assign TXF_AVAIL = cwp != frp;

	always_ff @(posedge CLK) begin
		if (OUT_WR && OUT_READY) begin
			obuf[owp[10:0]] <= OUT_DATA;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			owp <= 12'h000;
			cwp <= 12'h000;
		end else if (OUT_DONE) begin
			if (OUT_OK) begin
				cwp <= owp;
			end else begin
				owp <= cwp;
			end
		end else if (OUT_WR && OUT_READY) begin
			owp <= owp + 12'h001;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			frp <= 12'h000;
			TXF_DATA <= 32'h0000_0000;
		end else if (TXF_RD && TXF_AVAIL) begin
			TXF_DATA <= obuf[frp[10:0]];
			frp <= frp + 12'h001;
		end
	end

	// A new loss of sync wins over a software clear in the same cycle.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			out_stall_q <= 1'b0;
		end else if (LOS && !cfg[CFG_STALL_DIS]) begin
			out_stall_q <= 1'b1;
		end else if (stall_clr) begin
			out_stall_q <= 1'b0;
		end
	end
	assign OUT_STALL = out_stall_q;

	chk_noack_rewind: assert property (@(posedge CLK) disable iff (SYS_RST)
		IN_NOACK && outst |=> REWIND && snd_p == rd_p)
		else $error("missing rewind after lost ack");
	chk_ack_advance: assert property (@(posedge CLK) disable iff (SYS_RST)
		IN_ACK && outst |=> ADVANCE && rd_p == $past(rd_p) + 6'h01)
		else $error("ack did not pop the length entry");
	chk_empty_zlp: assert property (@(posedge CLK) disable iff (SYS_RST)
		IN_TOKEN && !(IN_NOACK && outst) && empty_all && !lim_en && !cfg[CFG_EMPTY_SEL]
		|=> IN_RSP.send && IN_RSP.len == 11'h000)
		else $error("empty fifo did not answer with a zlp");
	chk_wait_nrdy: assert property (@(posedge CLK) disable iff (SYS_RST)
		IN_RSP.nrdy || IN_RSP.nak |-> (IN_RSP.nrdy == (SPEED == SPD_SS)) && !IN_RSP.send)
		else $error("hold answer of wrong kind");
	chk_len_limit: assert property (@(posedge CLK) disable iff (SYS_RST)
		IN_RSP.send |-> IN_RSP.len <= mps)
		else $error("packet longer than max packet size");
	chk_cap_take: assert property (@(posedge CLK) disable iff (SYS_RST)
		do_take && lim_en && burst_cur != 26'h0 |-> burst_cur + 26'(RXF_LEN) <= burst_max)
		else $error("frame added beyond burst cap");
	chk_reject_restore: assert property (@(posedge CLK) disable iff (SYS_RST)
		OUT_DONE && !OUT_OK |=> owp == cwp && cwp == $past(cwp))
		else $error("rejected packet not rolled back");
	chk_los_stall: assert property (@(posedge CLK) disable iff (SYS_RST)
		LOS && !cfg[CFG_STALL_DIS] |=> OUT_STALL [*2])
		else $error("loss of sync did not stall");
	chk_ss_burst: assert property (@(posedge CLK) disable iff (SYS_RST)
		IN_TOKEN && SPEED == SPD_SS && term_cnt == 6'h00 && unsent < 6'(burst_sz)
		&& !(IN_NOACK && outst) |=> !IN_RSP.send || IN_RSP.len == 11'h000)
		else $error("superspeed sent before a whole burst");
	cov_rewind: cover property (@(posedge CLK) disable iff (SYS_RST) REWIND ##[1:50] ADVANCE);
	cov_close: cover property (@(posedge CLK) disable iff (SYS_RST) multi && do_close);
	cov_reject: cover property (@(posedge CLK) disable iff (SYS_RST) OUT_DONE && !OUT_OK);
endmodule

//--- bench/ubf_host_model.sv
// Host side model that issues Bulk In tokens and returns the packet handshakes.
module ubf_host_model
	import ubf_pkg::*;
(
	input wire logic CLK,
	input wire ubf_pkg::ubf_in_rsp_s IN_RSP,
	input wire logic REWIND,
	input wire logic ADVANCE,
	output logic IN_TOKEN,
	output logic IN_ACK,
	output logic IN_NOACK
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		IN_TOKEN = 1'h0;
		IN_ACK = 1'h0;
		IN_NOACK = 1'h0;
	end

	// The answer is registered, so it is taken in the one cycle it stands.
	task automatic tok(output ubf_in_rsp_s r);
		@(posedge CLK);
		IN_TOKEN <= 1'h1;
		@(posedge CLK);
		IN_TOKEN <= 1'h0;
		@(posedge CLK);
		r = IN_RSP;
	endtask

	// A slow host waits before answering; ok low stands for a lost handshake.
	task automatic hs(input logic ok, input int slow, output logic seen);
		repeat (slow) @(posedge CLK);
		IN_ACK <= ok;
		IN_NOACK <= !ok;
		@(posedge CLK);
		IN_ACK <= 1'h0;
		IN_NOACK <= 1'h0;
		@(posedge CLK);
		seen = ok ? ADVANCE : REWIND;
	endtask
endmodule

//--- bench/ubf_transport_tb.sv
// Self-checking bench for the bulk frame transport.
module ubf_transport_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ubf_pkg::*;
	logic CLK = 1'h0, SYS_RST = 1'h1;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, OUT_DATA = 32'h0, S_AXI_RDATA, TXF_DATA, d;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, RXF_AVAIL = 1'h0, RXF_MORE = 1'h0;
	logic OUT_WR = 1'h0, OUT_DONE = 1'h0, OUT_OK = 1'h0, LOS = 1'h0, TXF_RD = 1'h0;
	logic [13:0] RXF_LEN = 14'h0;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic RXF_TAKE, IN_TOKEN, IN_ACK, IN_NOACK, REWIND, ADVANCE;
	logic OUT_READY, OUT_STALL, TXF_AVAIL, seen;
	ubf_speed_e SPEED = SPD_FS;
	ubf_in_rsp_s IN_RSP, rsp;
	int miscompares = 0, checks = 0, cycles = 0, t0;

	ubf_transport i_ubf_transport (.CLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
		.S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
		.S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
		.S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .SPEED,
		.RXF_AVAIL, .RXF_LEN, .RXF_MORE, .RXF_TAKE, .IN_TOKEN, .IN_RSP, .IN_ACK, .IN_NOACK,
		.REWIND, .ADVANCE, .OUT_WR, .OUT_DATA, .OUT_READY, .OUT_DONE, .OUT_OK, .LOS,
		.OUT_STALL, .TXF_AVAIL, .TXF_RD, .TXF_DATA);
	ubf_host_model i_ubf_host_model (.CLK, .IN_RSP, .REWIND, .ADVANCE, .IN_TOKEN, .IN_ACK,
		.IN_NOACK);

	always #4 CLK = ~CLK;

	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
		checks++;
		if (seen_v !== exp_v) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do begin
			@(posedge CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
		end while (S_AXI_BVALID !== 1'h1);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do begin
			@(posedge CLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
		end while (S_AXI_RVALID !== 1'h1);
		v = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'h0;
	endtask

	// With more set the frame valid stays up so the next one follows at once.
	task automatic frame(input int n, input logic m);
		RXF_AVAIL <= 1'h1;
		RXF_LEN <= 14'(n);
		RXF_MORE <= m;
		do @(posedge CLK); while (RXF_TAKE !== 1'h1);
		if (!m) RXF_AVAIL <= 1'h0;
	endtask

	task automatic depth(input int n);
		do rd(REG_STATUS, d, resp); while (d[6:1] !== 6'(n));
	endtask

	task automatic pkt(input int n, input logic ok);
		i_ubf_host_model.tok(rsp);
		chk(32'(rsp), 32'({1'h1, 2'h0, 11'(n)}));
		i_ubf_host_model.hs(ok, 0, seen);
		chk(32'(seen), 32'h1);
	endtask

	task automatic owr(input logic [31:0] v, input logic keep);
		OUT_WR <= 1'h1;
		OUT_DATA <= v;
		do @(posedge CLK); while (OUT_READY !== 1'h1);
		if (!keep) OUT_WR <= 1'h0;
	endtask

	task automatic odone(input logic ok);
		OUT_DONE <= 1'h1;
		OUT_OK <= ok;
		@(posedge CLK);
		OUT_DONE <= 1'h0;
	endtask

	task automatic trd(input logic [31:0] e);
		do @(posedge CLK); while (TXF_AVAIL !== 1'h1);
		TXF_RD <= 1'h1;
		@(posedge CLK);
		TXF_RD <= 1'h0;
		@(posedge CLK);
		chk(TXF_DATA, e);
	endtask

	task automatic lost(input logic e);
		LOS <= 1'h1;
		@(posedge CLK);
		LOS <= 1'h0;
		@(posedge CLK);
		chk(32'(OUT_STALL), 32'(e));
	endtask

	initial begin
		repeat (4) @(posedge CLK);
		SYS_RST <= 1'h0;
		rd(REG_CFG, d, resp);
		chk(d, CFG_RESET);
		rd(REG_DELAY, d, resp);
		chk(d, DELAY_RESET);
		rd(REG_CAP, d, resp);
		chk(d, CAP_RESET);
		rd(8'h10, d, resp);
		chk(d, 32'h0);
		chk(32'(resp), 32'(RESP_SLVERR));
		wr(8'h10, 32'hFFFF_FFFF, resp);
		chk(32'(resp), 32'(RESP_SLVERR));
		// Single-frame packing at full speed; a lost handshake forces a resend.
		wr(REG_DELAY, 32'h0, resp);
		wr(REG_CFG, 32'h0, resp);
		frame(128, 1'h0);
		depth(3);
		i_ubf_host_model.tok(rsp);
		chk(32'(rsp.len), 32'(MPS_FS));
		i_ubf_host_model.hs(1'h0, 3, seen);
		chk(32'(seen), 32'h1);
		pkt(64, 1'h1);
		pkt(64, 1'h1);
		pkt(0, 1'h1);
		frame(70, 1'h1);
		frame(8, 1'h0);
		depth(3);
		pkt(64, 1'h1);
		pkt(6, 1'h1);
		pkt(8, 1'h1);
		depth(0);
		i_ubf_host_model.tok(rsp);
		chk(32'(rsp), 32'h2000);
		wr(REG_CFG, 32'h2, resp);
		SPEED <= SPD_HS;
		i_ubf_host_model.tok(rsp);
		chk(32'(rsp), 32'h1000);
		SPEED <= SPD_SS;
		i_ubf_host_model.tok(rsp);
		chk(32'(rsp), 32'h0800);
		// Multi-frame packing holds a lone short frame back for one microsecond.
		SPEED <= SPD_HS;
		wr(REG_DELAY, 32'h1, resp);
		wr(REG_CFG, 32'h1, resp);
		t0 = cycles;
		frame(100, 1'h0);
		i_ubf_host_model.tok(rsp);
		chk(32'(rsp), 32'h1000);
		depth(1);
		chk(32'(cycles - t0 >= CYC_PER_US), 32'h1);
		pkt(100, 1'h1);
		// A cap of two packets closes the burst before the third frame.
		SPEED <= SPD_FS;
		wr(REG_DELAY, 32'h0, resp);
		wr(REG_CAP, 32'h2, resp);
		wr(REG_CFG, 32'h5, resp);
		frame(60, 1'h1);
		frame(60, 1'h1);
		frame(60, 1'h0);
		depth(3);
		pkt(64, 1'h1);
		pkt(56, 1'h1);
		pkt(60, 1'h1);
		// Superspeed with a burst of two holds one full packet back until the terminator.
		SPEED <= SPD_SS;
		wr(REG_DELAY, 32'h2, resp);
		wr(REG_CFG, 32'h11, resp);
		frame(1100, 1'h0);
		i_ubf_host_model.tok(rsp);
		chk(32'(rsp), 32'h0800);
		depth(2);
		pkt(1024, 1'h1);
		pkt(76, 1'h1);
		// Bulk Out: accept, reject, then accept again into the freed space.
		owr(32'h1111_0001, 1'h1);
		owr(32'h2222_0002, 1'h0);
		odone(1'h1);
		trd(32'h1111_0001);
		trd(32'h2222_0002);
		owr(32'hBAD0_0BAD, 1'h0);
		odone(1'h0);
		@(posedge CLK);
		chk(32'(TXF_AVAIL), 32'h0);
		owr(32'h3333_0003, 1'h0);
		odone(1'h1);
		trd(32'h3333_0003);
		lost(1'h1);
		wr(REG_STATUS, 32'h1, resp);
		wr(REG_CFG, 32'h8, resp);
		lost(1'h0);
		end_sim();
	end
endmodule
